// ===== core/lfs_params.svh
/*
  Constants of the fault and status register port: register addresses,
  field positions, reset values and bus framing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define LFS_ADDR_CLEAR 8'h03
`define LFS_ADDR_FAULT 8'h78
`define LFS_ADDR_CHAN 8'hd0
`define LFS_ADDR_INFO 8'hd1

// ----------------------------------------------------------------
// Reset value and unmapped read value
// ----------------------------------------------------------------
`define LFS_RST_BYTE 8'h00
`define LFS_UNMAPPED_BYTE 8'h00

// ----------------------------------------------------------------
// Fault register field positions
// ----------------------------------------------------------------
`define LFS_F_PEAK_FLOAT 7
`define LFS_F_VREF_SHORT 6
`define LFS_F_CH1_BOOT_UV 5
`define LFS_F_CH2_BOOT_UV 4
`define LFS_F_CH1_ILIM 3
`define LFS_F_CH2_ILIM 2
`define LFS_F_OVP 1
`define LFS_F_TSD 0

// ----------------------------------------------------------------
// Bus framing
// ----------------------------------------------------------------
// Device bus address; value is arbitrary
`define LFS_DEV_ADDR 7'h2a
`define LFS_ACK_SLOT 4'h8

`endif

// ===== core/lfs_pkg.sv
/*
  Types shared by the fault and status register port.
  Assumes nothing of its surroundings.
*/
package lfs_pkg;

  // Phase of the current bus transfer, seen from the link side
  typedef enum logic [2:0] {
    PH_ADDR,
    PH_REG,
    PH_WDATA,
    PH_RDATA,
    PH_IGNORE
  } lfs_phase_t;

endpackage

// ===== core/lfs_i2c_regs.sv
/*
  Two-wire peripheral port with a latched fault register, a fault clear
  address and two read-only status registers.
  Assumes a controller that keeps to the bus protocol, status inputs that
  are asynchronous to clk_i, and an external pull-up on the data wire.
*/
`timescale 1ns/1ps
`include "lfs_params.svh"

// ----------------------------------------------------------------
// Two-stage synchroniser
// ----------------------------------------------------------------
module lfs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module lfs_i2c_regs (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic peak_limit_pin_float_i,
  input wire logic vref_short_i,
  input wire logic ch1_bootstrap_undervolt_i,
  input wire logic ch2_bootstrap_undervolt_i,
  input wire logic ch1_current_limit_hit_i,
  input wire logic ch2_current_limit_hit_i,
  input wire logic overvoltage_flag_i,
  input wire logic thermal_shutdown_flag_i,
  input wire logic ch1_enabled_flag_i,
  input wire logic ch2_enabled_flag_i,
  input wire logic ch1_diode_emulation_flag_i,
  input wire logic ch2_diode_emulation_flag_i,
  input wire logic ch1_direction_level_i,
  input wire logic ch2_direction_level_i,
  input wire logic ch1_direction_cmd_bad_i,
  input wire logic ch2_direction_cmd_bad_i,
  input wire logic [7:0] device_info_i,
  output logic [7:0] latched_faults_o
);

  // ----------------------------------------------------------------
  // Input synchronisers (system clock)
  // ----------------------------------------------------------------
  logic [7:0] fault_s;
  logic [7:0] chan_s;
  logic [7:0] info_s;
  logic [1:0] pin_s;
  logic [7:0] ptr_s;
  logic acc_s;
  logic [7:0] fault_raw;
  logic [7:0] chan_raw;
  logic [7:0] ptr_q;
  logic acc_tgl_q;

  assign fault_raw[`LFS_F_PEAK_FLOAT] = peak_limit_pin_float_i;
  assign fault_raw[`LFS_F_VREF_SHORT] = vref_short_i;
  assign fault_raw[`LFS_F_CH1_BOOT_UV] = ch1_bootstrap_undervolt_i;
  assign fault_raw[`LFS_F_CH2_BOOT_UV] = ch2_bootstrap_undervolt_i;
  assign fault_raw[`LFS_F_CH1_ILIM] = ch1_current_limit_hit_i;
  assign fault_raw[`LFS_F_CH2_ILIM] = ch2_current_limit_hit_i;
  assign fault_raw[`LFS_F_OVP] = overvoltage_flag_i;
  assign fault_raw[`LFS_F_TSD] = thermal_shutdown_flag_i;

  assign chan_raw[7:6] = {ch1_enabled_flag_i, ch2_enabled_flag_i};
  assign chan_raw[5:4] = {ch1_diode_emulation_flag_i, ch2_diode_emulation_flag_i};
  assign chan_raw[3:2] = {ch1_direction_level_i, ch2_direction_level_i};
  assign chan_raw[1:0] = {ch1_direction_cmd_bad_i, ch2_direction_cmd_bad_i};

  lfs_sync #(.W(8)) u_fault_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(fault_raw),
    .q_o(fault_s)
  );

  lfs_sync #(.W(8)) u_chan_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(chan_raw),
    .q_o(chan_s)
  );

  lfs_sync #(.W(8)) u_info_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(device_info_i),
    .q_o(info_s)
  );

  // Oversampling the wires at 40 MHz leaves ample margin at 1000 kbit/s
  lfs_sync #(.W(2)) u_pin_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i({scl_i, sda_i}),
    .q_o(pin_s)
  );

  // Pointer is quasi-static: it moves on a clock edge and then rests
  lfs_sync #(.W(8)) u_ptr_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(ptr_q),
    .q_o(ptr_s)
  );

  lfs_sync #(.W(1)) u_acc_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(acc_tgl_q),
    .q_o(acc_s)
  );

  // ----------------------------------------------------------------
  // Start and stop detection, link reset
  // ----------------------------------------------------------------
  logic [1:0] pin_p_q;
  logic bus_rst_q;
  logic acc_p_q;
  wire start_det = pin_s[1] & pin_p_q[1] & pin_p_q[0] & ~pin_s[0];
  wire stop_det = pin_s[1] & pin_p_q[1] & ~pin_p_q[0] & pin_s[0];
  // Pulse lands while the clock wire is high, so no link edge races it
  wire lrst_n = nrst_i & ~bus_rst_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_p_q <= 2'h3;
      bus_rst_q <= 1'b0;
      acc_p_q <= 1'b0;
    end else begin
      pin_p_q <= pin_s;
      bus_rst_q <= start_det | stop_det;
      acc_p_q <= acc_s;
    end
  end

  // ----------------------------------------------------------------
  // Register file (system clock)
  // ----------------------------------------------------------------
  logic [7:0] acc_addr_q;
  logic [7:0] acc_data_q;
  logic acc_wr_q;
  logic [7:0] flags_q;
  logic [7:0] clear_reg_q;
  logic [7:0] tx_q;
  wire acc_evt = acc_s ^ acc_p_q;
  wire clr = acc_evt & (acc_addr_q == `LFS_ADDR_CLEAR);
  wire clr_wr = clr & acc_wr_q;
  // A new event in the clearing cycle survives: set wins over clear
  wire [7:0] flags_d = (flags_q & ~{8{clr}}) | fault_s;
  wire [7:0] tx_d = (ptr_s == `LFS_ADDR_CLEAR) ? clear_reg_q :
                    (ptr_s == `LFS_ADDR_FAULT) ? flags_q :
                    (ptr_s == `LFS_ADDR_CHAN) ? chan_s :
                    (ptr_s == `LFS_ADDR_INFO) ? info_s :
                    `LFS_UNMAPPED_BYTE;

  // Only the clear address holds written data; other writes are dropped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_q <= `LFS_RST_BYTE;
      clear_reg_q <= `LFS_RST_BYTE;
      tx_q <= `LFS_RST_BYTE;
    end else begin
      flags_q <= flags_d;
      clear_reg_q <= clr_wr ? acc_data_q : clear_reg_q;
      tx_q <= tx_d;
    end
  end

  assign latched_faults_o = flags_q;

  // ----------------------------------------------------------------
  // Link framing (bus clock, reset by start and stop)
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  lfs_pkg::lfs_phase_t phase_q;
  logic [7:0] sr_q;
  logic [7:0] tx_sr_q;
  logic done_meta_q;
  logic done_s_q;
  logic oe_q;
  wire ack_slot = (cnt_q == `LFS_ACK_SLOT);
  wire addr_hit = (sr_q[7:1] == `LFS_DEV_ADDR);
  wire busy = acc_tgl_q ^ done_s_q;
  wire in_addr = (phase_q == lfs_pkg::PH_ADDR);
  wire in_reg = (phase_q == lfs_pkg::PH_REG);
  wire in_wdata = (phase_q == lfs_pkg::PH_WDATA);
  wire in_rdata = (phase_q == lfs_pkg::PH_RDATA);
  wire addr_ack = in_addr & addr_hit & ~busy;
  wire will_ack = addr_ack | in_reg | in_wdata;
  wire rd_start = ack_slot & addr_ack & sr_q[0];
  wire rd_more = ack_slot & in_rdata & ~sda_i;
  wire rd_load = rd_start | rd_more;

  always_ff @(posedge scl_i or negedge lrst_n) begin
    if (!lrst_n) begin
      cnt_q <= 4'h0;
      phase_q <= lfs_pkg::PH_ADDR;
      sr_q <= 8'h00;
      tx_sr_q <= 8'h00;
    end else if (!ack_slot) begin
      cnt_q <= cnt_q + 4'h1;
      sr_q <= {sr_q[6:0], sda_i};
      tx_sr_q <= {tx_sr_q[6:0], 1'b0};
    end else begin
      cnt_q <= 4'h0;
      tx_sr_q <= rd_load ? tx_q : tx_sr_q;
      case (phase_q)
        lfs_pkg::PH_ADDR: begin
          phase_q <= !addr_ack ? lfs_pkg::PH_IGNORE :
                     sr_q[0] ? lfs_pkg::PH_RDATA : lfs_pkg::PH_REG;
        end
        lfs_pkg::PH_REG: begin
          phase_q <= lfs_pkg::PH_WDATA;
        end
        lfs_pkg::PH_WDATA: begin
          phase_q <= lfs_pkg::PH_WDATA;
        end
        lfs_pkg::PH_RDATA: begin
          phase_q <= sda_i ? lfs_pkg::PH_IGNORE : lfs_pkg::PH_RDATA;
        end
        default: begin
          phase_q <= lfs_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pointer and access hand-off (bus clock, survive repeated start)
  // ----------------------------------------------------------------
  wire wr_byte = ack_slot & in_wdata;
  wire [7:0] ptr_d = (ack_slot & in_reg) ? sr_q :
                     (wr_byte | rd_load) ? ptr_q + 8'h01 :
                     ptr_q;

  always_ff @(posedge scl_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q <= 8'h00;
      acc_tgl_q <= 1'b0;
      acc_addr_q <= 8'h00;
      acc_data_q <= 8'h00;
      acc_wr_q <= 1'b0;
      done_meta_q <= 1'b0;
      done_s_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      done_meta_q <= acc_p_q;
      done_s_q <= done_meta_q;
      if (wr_byte | rd_load) begin
        acc_tgl_q <= ~acc_tgl_q;
        acc_addr_q <= ptr_q;
        acc_data_q <= sr_q;
        acc_wr_q <= wr_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Data wire drive on the falling bus clock
  // ----------------------------------------------------------------
  always_ff @(negedge scl_i or negedge lrst_n) begin
    if (!lrst_n) begin
      oe_q <= 1'b0;
    end else if (ack_slot) begin
      oe_q <= will_ack;
    end else begin
      oe_q <= in_rdata & ~tx_sr_q[7];
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_fault_latch: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (fault_s != 8'h00) |=> ((flags_q & $past(fault_s)) == $past(fault_s)))
    else $error("fault condition not latched");
  a_fault_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !clr |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("fault flag dropped without clear");
  a_fault_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (clr && fault_s == 8'h00) |=> (flags_q == 8'h00))
    else $error("clear access left flags set");
  a_fault_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ptr_s == `LFS_ADDR_FAULT) |=> (tx_q == $past(flags_q)))
    else $error("fault register read wrong");
  a_chan_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ptr_s == `LFS_ADDR_CHAN) |=> (tx_q[7:6] == $past(chan_s[7:6])))
    else $error("enable bits read wrong");
  a_mode_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ptr_s == `LFS_ADDR_CHAN) |=> (tx_q[5:0] == $past(chan_s[5:0])))
    else $error("mode or direction bits read wrong");
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ptr_s != `LFS_ADDR_CLEAR && ptr_s != `LFS_ADDR_FAULT &&
     ptr_s != `LFS_ADDR_CHAN && ptr_s != `LFS_ADDR_INFO) |=> (tx_q == 8'h00))
    else $error("unmapped address read nonzero");
  a_ro_nochange: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (acc_evt && acc_addr_q != `LFS_ADDR_CLEAR) |=> $stable(clear_reg_q))
    else $error("write elsewhere changed clear register");
  a_ptr_load: assert property (@(posedge scl_i) disable iff (!lrst_n)
    (ack_slot && in_reg) |=> (ptr_q == $past(sr_q)))
    else $error("register address not loaded");
  a_wr_incr: assert property (@(posedge scl_i) disable iff (!lrst_n)
    (ack_slot && in_wdata) |=> (ptr_q == $past(ptr_q) + 8'h01) && (acc_wr_q == 1'b1))
    else $error("pointer not advanced after write");
  a_rd_incr: assert property (@(posedge scl_i) disable iff (!lrst_n)
    (ack_slot && in_rdata && !sda_i) |=> (ptr_q == $past(ptr_q) + 8'h01) && in_rdata)
    else $error("pointer not advanced after read ack");
  a_seq_ack: assert property (@(posedge scl_i) disable iff (!lrst_n)
    (ack_slot && in_wdata) |-> sda_oe_o)
    else $error("written byte not acknowledged");
  a_busy_nack: assert property (@(posedge scl_i) disable iff (!lrst_n)
    (ack_slot && in_addr && busy) |-> !sda_oe_o)
    else $error("acknowledged while busy");

endmodule

// ===== sim/lfs_ctrl_model.sv
/*
  Behavioural bus controller facing the fault and status register port.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module lfs_ctrl_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  localparam realtime QP = 31.25;
  localparam realtime HOLD = 200.0;
  logic [1:0] res_kind = 2'h0;
  logic [7:0] res_val = 8'h00;
  event res_ev;

  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // Data set mid-low, sampled mid-high; clock stands still between frames
  task automatic slot(input logic low, output logic seen);
    #QP pull_o = low;
    #QP scl_o = 1'b1;
    #QP seen = sda_i;
    #QP scl_o = 1'b0;
  endtask

  task automatic report(input logic [1:0] k, input logic [7:0] v);
    res_kind = k;
    res_val = v;
    -> res_ev;
  endtask

  task automatic start();
    pull_o = 1'b1;
    #HOLD scl_o = 1'b0;
  endtask

  task automatic rstart();
    #QP pull_o = 1'b0;
    #QP scl_o = 1'b1;
    #HOLD pull_o = 1'b1;
    #HOLD scl_o = 1'b0;
  endtask

  task automatic stop();
    #QP pull_o = 1'b1;
    #QP scl_o = 1'b1;
    #HOLD pull_o = 1'b0;
    #HOLD;
  endtask

  task automatic wbyte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) slot(~b[i], a);
    slot(1'b0, a);
    report(2'h0, {7'h00, a});
  endtask

  // Acknowledge all but the last byte of a read
  task automatic rbyte(input logic last);
    logic [7:0] b;
    logic a;
    for (int i = 7; i >= 0; i--) slot(1'b0, b[i]);
    slot(~last, a);
    report(2'h1, b);
  endtask
endmodule

// ===== sim/tb.sv
/*
  Self-checking bench for the fault and status register port.
  Assumes the design files and the controller model compile first.
*/
`timescale 1ns/1ps
`include "lfs_params.svh"
module tb;
  localparam int TMO = 40000;
  logic clk_i = 1'b0;
  logic nrst_i, scl, pull, sda, sda_o, sda_oe;
  logic [7:0] flt, st, info, faults, ef, d;
  logic [9:0] expq[$];
  logic [9:0] em, efl;
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed;
  event flt_ev;

  always #12.5 clk_i = ~clk_i;
  assign sda = ~(pull | (sda_oe & ~sda_o));

  lfs_ctrl_model mdl (.sda_i(sda), .scl_o(scl), .pull_o(pull));
  lfs_i2c_regs dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .peak_limit_pin_float_i(flt[7]), .vref_short_i(flt[6]),
    .ch1_bootstrap_undervolt_i(flt[5]), .ch2_bootstrap_undervolt_i(flt[4]),
    .ch1_current_limit_hit_i(flt[3]), .ch2_current_limit_hit_i(flt[2]),
    .overvoltage_flag_i(flt[1]), .thermal_shutdown_flag_i(flt[0]),
    .ch1_enabled_flag_i(st[7]), .ch2_enabled_flag_i(st[6]),
    .ch1_diode_emulation_flag_i(st[5]), .ch2_diode_emulation_flag_i(st[4]),
    .ch1_direction_level_i(st[3]), .ch2_direction_level_i(st[2]),
    .ch1_direction_cmd_bad_i(st[1]), .ch2_direction_cmd_bad_i(st[0]),
    .device_info_i(info), .latched_faults_o(faults));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic tally(input logic ok, input string w, input logic [7:0] g, e);
    total_checks++;
    if (!ok) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask

  task automatic chk_ack(input logic [7:0] g, e);
    tally(g === e, "ack", g, e);
  endtask

  task automatic chk_byte(input logic [7:0] g, e);
    tally(g === e, "read byte", g, e);
  endtask

  task automatic chk_flt(input logic [7:0] g, e);
    tally(g === e, "fault reg", g, e);
  endtask

  task automatic pop(input logic [1:0] k, output logic [9:0] e);
    e = 10'h3ff;
    if (expq.size() > 0) e = expq.pop_front();
    tally(e[9:8] === k, "kind", {6'h00, e[9:8]}, {6'h00, k});
  endtask

  always @(mdl.res_ev) begin
    pop(mdl.res_kind, em);
    if (mdl.res_kind === 2'h0) chk_ack(mdl.res_val, em[7:0]);
    else chk_byte(mdl.res_val, em[7:0]);
  end

  always @(flt_ev) begin
    pop(2'h2, efl);
    chk_flt(faults, efl[7:0]);
  end

  // ----------------------------------------------------------------
  // Driving
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic ex(input logic [1:0] k, input logic [7:0] v);
    expq.push_back({k, v});
  endtask

  task automatic fchk(input logic [7:0] v);
    tick(6);
    ex(2'h2, v);
    -> flt_ev;
  endtask

  task automatic send(input logic [7:0] b);
    ex(2'h0, 8'h00);
    mdl.wbyte(b);
  endtask

  task automatic wr_seq(input logic [7:0] ra);
    mdl.start();
    send({`LFS_DEV_ADDR, 1'b0});
    send(ra);
    while (wq.size() > 0) send(wq.pop_front());
    mdl.stop();
    tick(20);
  endtask

  task automatic rd_seq(input logic [7:0] ra);
    int n;
    n = rq.size();
    mdl.start();
    send({`LFS_DEV_ADDR, 1'b0});
    send(ra);
    mdl.rstart();
    send({`LFS_DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      ex(2'h1, rq.pop_front());
      mdl.rbyte(i == n - 1);
    end
    mdl.stop();
    tick(20);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == TMO) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      print_verdict();
    end
  end

  initial begin
    nrst_i = 1'b0;
    flt = 8'h00;
    st = 8'h00;
    info = 8'h00;
    seed = $urandom(27);
    tick(5);
    nrst_i = 1'b1;
    tick(6);
    fchk(8'h00);
    rq = '{8'h00, 8'h00, 8'h00};
    rd_seq(8'h02);
    rq = '{8'h00, 8'h00};
    rd_seq(`LFS_ADDR_CHAN);
    $display("test reset values done");
    for (int k = 0; k < 3; k++) begin
      st = 8'($urandom);
      info = 8'($urandom);
      tick(4);
      rq = '{st, info};
      rd_seq(`LFS_ADDR_CHAN);
    end
    $display("test status done");
    ef = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      flt[b] = 1'b1;
      tick(4);
      flt[b] = 1'b0;
      ef[b] = 1'b1;
      fchk(ef);
    end
    // Writes to the fault, channel and info registers are dropped; reads return the old values
    wq = '{8'h00};
    wr_seq(`LFS_ADDR_FAULT);
    rq = '{ef};
    rd_seq(`LFS_ADDR_FAULT);
    fchk(ef);
    wq = '{~st, ~info};
    wr_seq(`LFS_ADDR_CHAN);
    rq = '{st, info};
    rd_seq(`LFS_ADDR_CHAN);
    $display("test fault latch done");
    d = 8'($urandom);
    wq = '{d};
    wr_seq(`LFS_ADDR_CLEAR);
    fchk(8'h00);
    rq = '{8'h00, d, 8'h00};
    rd_seq(8'h02);
    flt[0] = 1'b1;
    tick(4);
    flt[0] = 1'b0;
    fchk(8'h01);
    rq = '{d};
    rd_seq(`LFS_ADDR_CLEAR);
    fchk(8'h00);
    $display("test fault clear done");
    flt[3] = 1'b1;
    tick(4);
    flt[3] = 1'b0;
    fchk(8'h08);
    rq = '{8'h00, 8'h00, 8'h00, 8'h00, d};
    rd_seq(8'hff);
    fchk(8'h00);
    rq = '{d};
    rd_seq(`LFS_ADDR_CLEAR);
    $display("test pointer wrap done");
    mdl.start();
    ex(2'h0, 8'h01);
    mdl.wbyte({`LFS_DEV_ADDR ^ 7'h01, 1'b0});
    mdl.stop();
    tick(20);
    rq = '{d};
    rd_seq(`LFS_ADDR_CLEAR);
    $display("test foreign address done");
    tally(expq.size() == 0, "left over", 8'(expq.size()), 8'h00);
    print_verdict();
  end
endmodule
